// File: src/pin_mux_cfg.svh
/*
  register addresses, reset values and bit-space base addresses for the bit ports and
  pass-through multiplexers; assumes an 8-bit core data bus
*/
`ifndef PIN_MUX_CFG_SVH
`define PIN_MUX_CFG_SVH

`define ADDR_BIT_PORT_LOW_IO        16'h0080
`define ADDR_BIT_PORT_HIGH_IO       16'h0090
`define ADDR_PASS_THROUGH_SELECT    16'h7f85
`define ADDR_BIT_PORT_LOW_DIRECTION 16'h7fad
`define ADDR_BIT_PORT_HIGH_DIRECTION 16'h7fae
`define RESET_BYTE                  8'h00
`define BIT_SPACE_LOW_BASE          8'h80
`define BIT_SPACE_HIGH_BASE         8'h90

`endif

// File: src/pin_mux_pkg.sv
/*
  types shared by the pin logic; assumes nothing beyond the cfg header
*/
package pin_mux_pkg;
  typedef logic [7:0] byte_t;
  typedef enum logic [1:0] {
    SPACE_SFR  = 2'b00,
    SPACE_XMEM = 2'b01,
    SPACE_BIT  = 2'b11
  } space_e;
endpackage

// File: src/bit_gpio_and_pass_through_mux.sv
/*
  bit ports, their direction registers and eight pass-through multiplexers.
  assumes the core issues one access per cycle; pin inputs are asynchronous
  and pass two flip-flops before use
*/
// Function
// [R1] low bit port at sfr 0x80, resets zero
// [R2] low port direction register, one means output
// [R3] high bit port at sfr 0x90, resets zero
// [R4] high port direction register, same encoding
// [R5] eight independent pass-through pairs
// [R6] source pin k pairs target pin k
// [R7] pass select register, bit k pair k
// [R8] select zero: both pins ordinary
// [R9] select one: target carries source signal
// [R10] only core accesses select register
// [R11] passing target is always an output
// [R12] normal target direction from own bit
// [R13] passing target input not reflected
// [R14] source pins always raise core events
// [R15] shared io address, input pins read live
// [R16] single-bit set and clear per pin
// [R17] output source drives its output value
// [R18] control registers read back last write
`timescale 1ns/1ps
`include "pin_mux_cfg.svh"

module bit_gpio_and_pass_through_mux
  import pin_mux_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        core_req,
  input  wire space_e      core_space,
  input  wire logic        core_write,
  input  wire logic [15:0] core_addr,
  input  wire logic [7:0]  core_wdata,
  input  wire logic        core_bit_value,
  output logic      [7:0]  core_rdata,
  output logic             core_rvalid,
  input  wire logic [7:0]  bit_port_low_pin_in,
  output logic      [7:0]  bit_port_low_pin_out,
  output logic      [7:0]  bit_port_low_pin_oe_n,
  input  wire logic [7:0]  bit_port_high_pin_in,
  output logic      [7:0]  bit_port_high_pin_out,
  output logic      [7:0]  bit_port_high_pin_oe_n,
  input  wire logic [7:0]  source_pin_in,
  input  wire logic [7:0]  source_pin_out_value,
  input  wire logic [7:0]  source_pin_dir,
  input  wire logic [7:0]  target_pin_in,
  input  wire logic [7:0]  target_pin_out_value,
  input  wire logic [7:0]  target_pin_dir,
  output logic      [7:0]  target_pin_out,
  output logic      [7:0]  target_pin_oe_n,
  output logic      [7:0]  target_pin_status,
  output logic      [7:0]  source_pin_event
);

  // ==========================================================
  // registers
  byte_t bit_port_low_io;
  byte_t bit_port_high_io;
  byte_t bit_port_low_direction;
  byte_t bit_port_high_direction;
  byte_t pass_through_select;

  // ==========================================================
  // pin synchronisers
  byte_t low_meta, low_sync, high_meta, high_sync;
  byte_t src_meta, src_sync, tgt_meta, tgt_sync, src_prev;

  // events compare the two settled stages, never the first one
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      low_meta  <= `RESET_BYTE;
      low_sync  <= `RESET_BYTE;
      high_meta <= `RESET_BYTE;
      high_sync <= `RESET_BYTE;
      src_meta  <= `RESET_BYTE;
      src_sync  <= `RESET_BYTE;
      tgt_meta  <= `RESET_BYTE;
      tgt_sync  <= `RESET_BYTE;
      src_prev  <= `RESET_BYTE;
    end else begin
      low_meta  <= bit_port_low_pin_in;
      low_sync  <= low_meta;
      high_meta <= bit_port_high_pin_in;
      high_sync <= high_meta;
      src_meta  <= source_pin_in;
      src_sync  <= src_meta;
      tgt_meta  <= target_pin_in;
      tgt_sync  <= tgt_meta;
      src_prev  <= src_sync;
    end
  end

  // ==========================================================
  // address decode
  logic       wr, rd;
  logic       bit_hit_low, bit_hit_high;
  logic [2:0] bit_idx;

  assign wr = core_req && core_write;
  assign rd = core_req && !core_write;
  assign bit_idx = core_addr[2:0];
  // bit space fits one byte, so the upper address byte is not decoded
  assign bit_hit_low  = wr && core_space == SPACE_BIT &&
                        core_addr[7:3] == 5'(`BIT_SPACE_LOW_BASE >> 3);
  assign bit_hit_high = wr && core_space == SPACE_BIT &&
                        core_addr[7:3] == 5'(`BIT_SPACE_HIGH_BASE >> 3);

  function automatic logic sfr_hit(input logic [15:0] a, input logic [15:0] r);
    sfr_hit = core_space == SPACE_SFR && a == r;
  endfunction

  function automatic logic xm_hit(input logic [15:0] a, input logic [15:0] r);
    xm_hit = core_space == SPACE_XMEM && a == r;
  endfunction

  // ==========================================================
  // bit port latches
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bit_port_low_io <= `RESET_BYTE;                                  // [R1]
    end else if (wr && sfr_hit(core_addr, `ADDR_BIT_PORT_LOW_IO)) begin
      bit_port_low_io <= core_wdata;                                   // [R15]
    end else if (bit_hit_low) begin
      bit_port_low_io[bit_idx] <= core_bit_value;                      // [R16]
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bit_port_high_io <= `RESET_BYTE;                                 // [R3]
    end else if (wr && sfr_hit(core_addr, `ADDR_BIT_PORT_HIGH_IO)) begin
      bit_port_high_io <= core_wdata;                                  // [R15]
    end else if (bit_hit_high) begin
      bit_port_high_io[bit_idx] <= core_bit_value;                     // [R16]
    end
  end

  // ==========================================================
  // direction and pass select registers, core side only
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bit_port_low_direction <= `RESET_BYTE;                           // [R2]
    end else if (wr && xm_hit(core_addr, `ADDR_BIT_PORT_LOW_DIRECTION)) begin
      bit_port_low_direction <= core_wdata;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bit_port_high_direction <= `RESET_BYTE;                          // [R4]
    end else if (wr && xm_hit(core_addr, `ADDR_BIT_PORT_HIGH_DIRECTION)) begin
      bit_port_high_direction <= core_wdata;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pass_through_select <= `RESET_BYTE;                              // [R7]
    end else if (wr && xm_hit(core_addr, `ADDR_PASS_THROUGH_SELECT)) begin
      pass_through_select <= core_wdata;                               // [R10]
    end
  end

  // ==========================================================
  // read back
  byte_t low_read, high_read, next_rdata;

  assign low_read  = (bit_port_low_direction & bit_port_low_io) |
                     (~bit_port_low_direction & low_sync);             // [R15]
  assign high_read = (bit_port_high_direction & bit_port_high_io) |
                     (~bit_port_high_direction & high_sync);

  always_comb begin
    next_rdata = `RESET_BYTE;
    if (sfr_hit(core_addr, `ADDR_BIT_PORT_LOW_IO)) begin
      next_rdata = low_read;
    end else if (sfr_hit(core_addr, `ADDR_BIT_PORT_HIGH_IO)) begin
      next_rdata = high_read;
    end else if (xm_hit(core_addr, `ADDR_BIT_PORT_LOW_DIRECTION)) begin
      next_rdata = bit_port_low_direction;                             // [R18]
    end else if (xm_hit(core_addr, `ADDR_BIT_PORT_HIGH_DIRECTION)) begin
      next_rdata = bit_port_high_direction;
    end else if (xm_hit(core_addr, `ADDR_PASS_THROUGH_SELECT)) begin
      next_rdata = pass_through_select;
    end
  end

  // rdata is zero outside a read so a stale byte never leaks
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      core_rdata  <= `RESET_BYTE;
      core_rvalid <= 1'b0;
    end else begin
      core_rvalid <= rd;
      core_rdata  <= rd ? next_rdata : `RESET_BYTE;
    end
  end

  // ==========================================================
  // bit port pin drivers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bit_port_low_pin_out   <= `RESET_BYTE;
      bit_port_low_pin_oe_n  <= ~`RESET_BYTE;
      bit_port_high_pin_out  <= `RESET_BYTE;
      bit_port_high_pin_oe_n <= ~`RESET_BYTE;
    end else begin
      bit_port_low_pin_out   <= bit_port_low_io;
      bit_port_low_pin_oe_n  <= ~bit_port_low_direction;              // [R2]
      bit_port_high_pin_out  <= bit_port_high_io;
      bit_port_high_pin_oe_n <= ~bit_port_high_direction;             // [R4]
    end
  end

  // ==========================================================
  // pass-through multiplexers
  byte_t next_target_out, next_target_oe_n, next_status, pass_value;

  // output source carries its driven value, input source its pin level
  assign pass_value = (source_pin_dir & source_pin_out_value) |
                      (~source_pin_dir & src_sync);                    // [R17]

  always_comb begin
    next_target_out  = `RESET_BYTE;
    next_target_oe_n = `RESET_BYTE;
    next_status      = `RESET_BYTE;
    for (int k = 0; k < 8; k++) begin                                  // [R5] [R6]
      if (pass_through_select[k]) begin
        next_target_out[k]  = pass_value[k];                           // [R9]
        next_target_oe_n[k] = 1'b0;                                    // [R11]
        next_status[k]      = 1'b0;                                    // [R13]
      end else begin
        next_target_out[k]  = target_pin_out_value[k];                 // [R8]
        next_target_oe_n[k] = ~target_pin_dir[k];                      // [R12]
        next_status[k]      = tgt_sync[k];
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      target_pin_out    <= `RESET_BYTE;
      target_pin_oe_n   <= ~`RESET_BYTE;
      target_pin_status <= `RESET_BYTE;
      source_pin_event  <= `RESET_BYTE;
    end else begin
      target_pin_out    <= next_target_out;
      target_pin_oe_n   <= next_target_oe_n;
      target_pin_status <= next_status;
      source_pin_event  <= src_sync ^ src_prev;                        // [R14]
    end
  end

  // ==========================================================
  // assertions
  a_low_reset_zero: assert property (@(posedge clk)                    // [R1]
    $rose(nrst) |-> bit_port_low_io == 8'h00)
    else $error("low port latch not zero after reset");
  a_pass_drives: assert property (@(posedge clk) disable iff (!nrst)   // [R11]
    pass_through_select[0] |=> target_pin_oe_n[0] == 1'b0)
    else $error("passing target not driven");
  a_normal_dir: assert property (@(posedge clk) disable iff (!nrst)    // [R12]
    !pass_through_select[3] |=> target_pin_oe_n[3] == !$past(target_pin_dir[3]))
    else $error("normal target direction wrong");
  a_pass_value: assert property (@(posedge clk) disable iff (!nrst)    // [R9]
    pass_through_select[2] && !source_pin_dir[2] |=>
      target_pin_out[2] == $past(src_sync[2]))
    else $error("target does not carry source");
  a_pass_hides: assert property (@(posedge clk) disable iff (!nrst)    // [R13]
    pass_through_select != 8'h00 |=>
      (target_pin_status & $past(pass_through_select)) == 8'h00)
    else $error("passing target status visible");
  a_bit_set: assert property (@(posedge clk) disable iff (!nrst)       // [R16]
    bit_hit_low |=> bit_port_low_io ==
      (($past(bit_port_low_io) & ~(8'h01 << $past(bit_idx))) |
      ({7'h00, $past(core_bit_value)} << $past(bit_idx))))
    else $error("bit write disturbed other bits");
  a_sel_readback: assert property (@(posedge clk) disable iff (!nrst)  // [R18]
    wr && xm_hit(core_addr, `ADDR_PASS_THROUGH_SELECT) ##1 !core_req ##1
      rd && xm_hit(core_addr, `ADDR_PASS_THROUGH_SELECT) |=>
      core_rdata == $past(core_wdata, 3))
    else $error("select register readback wrong");
  a_live_input: assert property (@(posedge clk) disable iff (!nrst)    // [R15]
    rd && sfr_hit(core_addr, `ADDR_BIT_PORT_HIGH_IO) && bit_port_high_direction == 8'h00
      |=> core_rdata == $past(high_sync))
    else $error("input pin level not read live");
  a_source_event: assert property (@(posedge clk) disable iff (!nrst)  // [R14]
    src_sync[0] != src_prev[0] |=> source_pin_event[0])
    else $error("source edge lost under pass-through");
  a_high_reset_zero: assert property (@(posedge clk)                   // [R2] [R3] [R4] [R7]
    $rose(nrst) |-> {bit_port_high_io, bit_port_low_direction,
                     bit_port_high_direction, pass_through_select} == 32'h00000000)
    else $error("control register not zero after reset");
  a_byte_write: assert property (@(posedge clk) disable iff (!nrst)    // [R15]
    wr && sfr_hit(core_addr, `ADDR_BIT_PORT_LOW_IO) |=>
      bit_port_low_io == $past(core_wdata))
    else $error("port byte write lost");
  a_high_bit: assert property (@(posedge clk) disable iff (!nrst)      // [R16]
    bit_hit_high |=> bit_port_high_io ==
      (($past(bit_port_high_io) & ~(8'h01 << $past(bit_idx))) |
      ({7'h00, $past(core_bit_value)} << $past(bit_idx))))
    else $error("high port bit write disturbed other bits");
  a_dir_write: assert property (@(posedge clk) disable iff (!nrst)     // [R4]
    wr && xm_hit(core_addr, `ADDR_BIT_PORT_HIGH_DIRECTION) |=>
      bit_port_high_direction == $past(core_wdata))
    else $error("direction write lost");
  a_sel_write: assert property (@(posedge clk) disable iff (!nrst)     // [R7] [R10]
    wr && xm_hit(core_addr, `ADDR_PASS_THROUGH_SELECT) |=>
      pass_through_select == $past(core_wdata))
    else $error("select write lost");
  a_port_oe: assert property (@(posedge clk) disable iff (!nrst)       // [R2] [R4]
    1'b1 |=> {bit_port_low_pin_oe_n, bit_port_high_pin_oe_n} ==
      ~{$past(bit_port_low_direction), $past(bit_port_high_direction)})
    else $error("port drive enable wrong");
  a_normal_value: assert property (@(posedge clk) disable iff (!nrst)  // [R8]
    pass_through_select != 8'hff |=> ((target_pin_out ^ $past(target_pin_out_value)) &
      ~$past(pass_through_select)) == 8'h00)
    else $error("normal target drive wrong");
  a_pass_outsrc: assert property (@(posedge clk) disable iff (!nrst)   // [R17]
    pass_through_select[1] && source_pin_dir[1] |=>
      target_pin_out[1] == $past(source_pin_out_value[1]))
    else $error("output source value not passed");
  a_read_pulse: assert property (@(posedge clk) disable iff (!nrst)    // [R15]
    rd |=> core_rvalid)
    else $error("read not answered");
  a_idle_quiet: assert property (@(posedge clk) disable iff (!nrst)    // [R15]
    !rd |=> !core_rvalid && core_rdata == 8'h00)
    else $error("read data outside a read");

  // ==========================================================
  // coverage of the main scenarios
  c_pass_on: cover property (@(posedge clk) disable iff (!nrst)
    $rose(pass_through_select[7]));
  c_bit_clear: cover property (@(posedge clk) disable iff (!nrst)
    bit_hit_high && !core_bit_value);
  c_readback: cover property (@(posedge clk) disable iff (!nrst)
    core_rvalid && core_rdata != 8'h00);
  c_pass_outsrc: cover property (@(posedge clk) disable iff (!nrst)
    pass_through_select[1] && source_pin_dir[1]);
  c_live_read: cover property (@(posedge clk) disable iff (!nrst)
    rd && sfr_hit(core_addr, `ADDR_BIT_PORT_HIGH_IO) && bit_port_high_direction == 8'h00);

endmodule // bit_gpio_and_pass_through_mux

// File: tb/pin_board_model.sv
/*
  board side of one 8-pin group: resolves each wire from the device drive
  and the board's own level; assumes the oe_n outputs of the pin logic
*/
`timescale 1ns/1ps

module pin_board_model (
  input  wire logic [7:0] board_level,
  input  wire logic [7:0] dev_out,
  input  wire logic [7:0] dev_oe_n,
  output logic      [7:0] pin_level
);
  // device wins where it drives, the board sets every released wire
  assign pin_level = (dev_out & ~dev_oe_n) | (board_level & dev_oe_n);
endmodule // pin_board_model

// File: tb/bit_gpio_and_pass_through_mux_tb_top.sv
/*
  self-checking bench for the pin logic; assumes the design, its package,
  the cfg header and the board model are compiled before it
*/
`timescale 1ns/1ps
`include "pin_mux_cfg.svh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_errors++; \
  $display("wrong value at %0t: got %h expected %h", $time, g, e); end end

module bit_gpio_and_pass_through_mux_tb_top;
  import pin_mux_pkg::*;
  typedef struct { space_e s; logic [15:0] a; logic [7:0] d; logic [7:0] e; } row_s;
  logic clk = 0, nrst = 0, core_req = 0, core_write = 0, core_bit_value = 0, core_rvalid;
  space_e core_space = SPACE_SFR;
  logic [15:0] core_addr = 16'h0000;
  logic [7:0] core_wdata = 8'h00, core_rdata, rd, lo_b = 8'h50, hi_b = 8'h00;
  logic [7:0] src_b = 8'h00, tgt_b = 8'h00, s_val = 8'h00, s_dir = 8'h00;
  logic [7:0] t_val = 8'h00, t_dir = 8'h00, lo_in, lo_out, lo_oe_n, hi_in, hi_out, hi_oe_n;
  logic [7:0] t_in, t_out, t_oe_n, t_stat, s_evt;
  logic [3:0] hits;
  int n_errors = 0, samples_checked = 0;
  row_s rows [8] = '{
    '{SPACE_XMEM, `ADDR_BIT_PORT_LOW_DIRECTION, 8'ha5, 8'ha5},
    '{SPACE_XMEM, `ADDR_BIT_PORT_HIGH_DIRECTION, 8'h3c, 8'h3c},
    '{SPACE_XMEM, `ADDR_PASS_THROUGH_SELECT, 8'h81, 8'h81},
    '{SPACE_XMEM, `ADDR_PASS_THROUGH_SELECT, 8'h00, 8'h00},
    '{SPACE_XMEM, 16'h7fa0, 8'hff, 8'h00},
    '{SPACE_SFR, `ADDR_BIT_PORT_LOW_IO, 8'hff, 8'hf5},
    '{SPACE_SFR, `ADDR_BIT_PORT_HIGH_IO, 8'h0f, 8'h0c},
    '{SPACE_SFR, 16'h0085, 8'h77, 8'h00}};

  always #2.5 clk = ~clk;

  bit_gpio_and_pass_through_mux i_bit_gpio_and_pass_through_mux (
    .clk(clk), .nrst(nrst), .core_req(core_req), .core_space(core_space),
    .core_write(core_write), .core_addr(core_addr), .core_wdata(core_wdata),
    .core_bit_value(core_bit_value), .core_rdata(core_rdata), .core_rvalid(core_rvalid),
    .bit_port_low_pin_in(lo_in), .bit_port_low_pin_out(lo_out),
    .bit_port_low_pin_oe_n(lo_oe_n), .bit_port_high_pin_in(hi_in),
    .bit_port_high_pin_out(hi_out), .bit_port_high_pin_oe_n(hi_oe_n),
    .source_pin_in(src_b), .source_pin_out_value(s_val), .source_pin_dir(s_dir),
    .target_pin_in(t_in), .target_pin_out_value(t_val), .target_pin_dir(t_dir),
    .target_pin_out(t_out), .target_pin_oe_n(t_oe_n), .target_pin_status(t_stat),
    .source_pin_event(s_evt));
  pin_board_model i_lo (.board_level(lo_b), .dev_out(lo_out), .dev_oe_n(lo_oe_n),
    .pin_level(lo_in));
  pin_board_model i_hi (.board_level(hi_b), .dev_out(hi_out), .dev_oe_n(hi_oe_n),
    .pin_level(hi_in));
  pin_board_model i_tg (.board_level(tgt_b), .dev_out(t_out), .dev_oe_n(t_oe_n),
    .pin_level(t_in));

  // ==========================================================
  // core access and closing tasks
  task automatic acc(input space_e s, input logic w, input logic [15:0] a,
                     input logic [7:0] d, input logic b, output logic [7:0] r);
    @(posedge clk);
    #1;
    core_req = 1'b1; core_space = s; core_write = w;
    core_addr = a; core_wdata = d; core_bit_value = b;
    @(posedge clk);
    #1;
    core_req = 1'b0;
    r = core_rdata;
    if (!w) `CHK(core_rvalid, 1'b1)
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // ==========================================================
  // main sequence
  initial begin
    wt(2);
    nrst = 1'b1;
    foreach (rows[i]) begin
      acc(rows[i].s, 1'b1, rows[i].a, rows[i].d, 1'b0, rd);
      acc(rows[i].s, 1'b0, rows[i].a, 8'h00, 1'b0, rd);
      `CHK(rd, rows[i].e)
    end
    `CHK({lo_out, lo_oe_n, hi_oe_n}, 24'hff5ac3)
    acc(SPACE_BIT, 1'b1, 16'h0083, 8'h00, 1'b0, rd);
    acc(SPACE_BIT, 1'b1, 16'h0097, 8'h00, 1'b1, rd);
    acc(SPACE_BIT, 1'b1, 16'h0098, 8'h00, 1'b0, rd);
    wt(2);
    `CHK({lo_out, hi_out}, 16'hf78f)
    t_val = 8'hff; t_dir = 8'h0f; tgt_b = 8'haa; src_b = 8'h05;
    wt(5);
    `CHK({t_oe_n, t_out[3:0], t_stat[7:4]}, 16'hf0fa)
    acc(SPACE_XMEM, 1'b1, `ADDR_PASS_THROUGH_SELECT, 8'h0f, 1'b0, rd);
    t_dir = 8'h00;
    wt(4);
    `CHK({t_oe_n, t_out[3:0], t_stat}, 20'hf05a0)
    s_dir = 8'hff; s_val = 8'h0a;
    wt(2);
    `CHK(t_out[3:0], 4'ha)
    src_b = 8'h04;
    hits = 4'h0;
    for (int n = 0; n < 8; n++) begin
      @(posedge clk);
      #1;
      if (s_evt === 8'h01) hits++;
    end
    `CHK(hits, 4'h1)
    lo_b = 8'h00;
    nrst = 1'b0;
    #1;
    `CHK({lo_oe_n, hi_oe_n, t_oe_n, core_rvalid}, 25'h1fffffe)
    wt(2);
    nrst = 1'b1;
    foreach (rows[i]) begin
      acc(rows[i].s, 1'b0, rows[i].a, 8'h00, 1'b0, rd);
      `CHK(rd, 8'h00)
    end
    end_of_test();
  end

  initial begin
    #100000;
    n_errors++;
    end_of_test();
  end
endmodule // bit_gpio_and_pass_through_mux_tb_top
